//--- verification/dpll_monitor_control_properties.sv
module dpll_monitor_control_properties
  import dpll_ctrl_pkg::*;
(
  input wire logic          clk,                      // Clock
  input wire logic          rst,                      // Reset
  input wire host_req_t     host_req,                 // Host request
  input wire logic [15:0]   host_rdata,               // Read data
  input wire det_freq_arr_t det_freq,                 // Detectors
  input wire logic [1:0]    active_ref,               // Tracked ref
  input wire ref_meas_arr_t ref_meas,                 // Offsets
  input wire logic [15:0]   ref_frequency_value,      // Loop feed
  input wire logic          pll_run,                  // Running
  input wire logic          pll_sleep_mode,           // Sleep bit
  input wire logic          strict_limit_select,      // Limit bit
  input wire logic          fixed_freq_source_enable, // Source bit
  input wire logic [3:0]    ref_out_of_range          // Verdicts
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] freq_shadow_ff;
  // Shadow of the software word, so the fixed path is judged without peeking inside
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      freq_shadow_ff <= REF_FREQ_RST;
    else if (host_req.wr && host_req.addr == REF_FREQ_ADDR)
      freq_shadow_ff <= host_req.wdata;
  end
  // A write that reaches the control word
  sequence s_ctrl_wr;
    host_req.wr && host_req.addr == PLL_CONTROL_ADDR;
  endsequence
  a_limit_bit_kept: assert property (s_ctrl_wr |=> strict_limit_select == $past(host_req.wdata[5]))
    else $error("limit bit not taken");
  a_sleep_entry: assert property (s_ctrl_wr ##0 host_req.wdata[0] |=> pll_sleep_mode ##1 !pll_run)
    else $error("sleep not entered");
  a_wake_entry: assert property (s_ctrl_wr ##0 !host_req.wdata[0] |=> !pll_sleep_mode ##1 pll_run)
    else $error("loop not running");
  a_sleep_freeze: assert property (!pll_run [*2] |-> $stable(ref_frequency_value))
    else $error("feed moved while asleep");
  a_detector_path: assert property (pll_run && !fixed_freq_source_enable
    |=> ref_frequency_value == $past(det_freq[active_ref]))
    else $error("detector value not fed");
  a_fixed_path: assert property (pll_run && fixed_freq_source_enable
    |=> ref_frequency_value == $past(freq_shadow_ff))
    else $error("register value not fed");
  a_strict_edge: assert property (pll_run && strict_limit_select
    && ref_meas[0].inst_offset == 20'h0FCCA |=> ref_out_of_range[0])
    else $error("strict limit missed");
  a_relax_edge: assert property (pll_run && !strict_limit_select
    && ref_meas[0].inst_offset == 20'h3A981 |=> ref_out_of_range[0])
    else $error("relaxed limit missed");
  a_ctrl_readback: assert property (host_req.rd && host_req.addr == PLL_CONTROL_ADDR |=> host_rdata ==
    {10'h000, $past(strict_limit_select), 3'h0, $past(fixed_freq_source_enable), $past(pll_sleep_mode)})
    else $error("control readback wrong");
endmodule : dpll_monitor_control_properties

//--- verification/dpll_monitor_control_tb_top.sv
module dpll_monitor_control_tb_top
  import dpll_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic strict; logic [19:0] inst; logic [19:0] lng; logic exp;} row_t;
  logic          clk, rst, pll_run, pll_sleep_mode, strict_limit_select, fixed_freq_source_enable;
  host_req_t     host_req;
  logic [15:0]   host_rdata, ref_frequency_value;
  det_freq_arr_t det_freq;
  logic [1:0]    active_ref;
  ref_meas_arr_t ref_meas;
  logic [3:0]    ref_out_of_range;
  int            fails, n_compared;
  // Limit edges in milli-ppm: FCC9/FCCA = 64713/64714, 3A980 = 240000, C2F70 = -250000
  row_t rows [8] = '{'{1'b1, 20'h0FCC9, 20'h14237, 1'b0}, '{1'b1, 20'h0FCCA, 20'h00000, 1'b1},
    '{1'b1, 20'hF0336, 20'h00000, 1'b1}, '{1'b1, 20'h00000, 20'h14238, 1'b1},
    '{1'b0, 20'h3A980, 20'hC2F70, 1'b0}, '{1'b0, 20'h3A981, 20'h00000, 1'b1},
    '{1'b0, 20'h00000, 20'hC2F6F, 1'b1}, '{1'b0, 20'h0FCCA, 20'h14238, 1'b0}};
  dpll_monitor_control dut_u (.clk, .rst, .host_req, .host_rdata, .det_freq, .active_ref, .ref_meas,
    .ref_frequency_value, .pll_run, .pll_sleep_mode, .strict_limit_select, .fixed_freq_source_enable,
    .ref_out_of_range);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Inputs move 1 ns after the edge so the design never races the bench
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic put(input logic [13:0] a, input logic [15:0] d);
    host_req = '{1'b1, 1'b0, a, d};
    tick(1);
    host_req.wr = 1'b0;
    tick(1);
  endtask : put
  task automatic rd_chk(input logic [13:0] a, input logic [15:0] exp);
    host_req = '{1'b0, 1'b1, a, 16'h0000};
    tick(1);
    host_req.rd = 1'b0;
    check(host_rdata, exp);
    // Read data stands one cycle only; the extra edge also parts two reads
    tick(1);
    check(host_rdata, READ_IDLE);
  endtask : rd_chk
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run needs about 70 cycles; this is a generous margin
  initial begin
    #20us;
    fails++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    host_req = '0;
    det_freq = '0;
    active_ref = 2'h0;
    ref_meas = '0;
    tick(8);
    check({8'h00, host_rdata[3:0], pll_run, pll_sleep_mode, strict_limit_select, fixed_freq_source_enable}, 16'h0000);
    rst = 1'b0;
    tick(1);
    check({15'h0000, pll_run}, 16'h0001);
    $display("reset test done");
    // Reserved bits stay zero in every control word this loop sends
    foreach (rows[i]) begin
      put(PLL_CONTROL_ADDR, {10'h000, rows[i].strict, 5'h00});
      ref_meas = {4{rows[i].inst, rows[i].lng}};
      tick(2);
      check({12'h000, ref_out_of_range}, rows[i].exp ? 16'h000F : 16'h0000);
    end
    $display("monitor table done");
    det_freq = {16'h4444, 16'h3333, 16'h2222, 16'h1111};
    active_ref = 2'h2;
    tick(2);
    check(ref_frequency_value, 16'h3333);
    put(REF_FREQ_ADDR, 16'h1234);
    put(PLL_CONTROL_ADDR, 16'h0002);
    det_freq = '0;
    // Offsets in range, so the verdict frozen at sleep entry is known to be clear
    ref_meas = '0;
    tick(1);
    check(ref_frequency_value, 16'h1234);
    $display("source test done");
    put(PLL_CONTROL_ADDR, 16'h0023);
    check({15'h0000, pll_run}, 16'h0000);
    check({13'h0000, strict_limit_select, fixed_freq_source_enable, pll_sleep_mode}, 16'h0007);
    put(REF_FREQ_ADDR, 16'h5678);
    ref_meas = {4{20'h7FFFF, 20'h7FFFF}};
    tick(2);
    check({ref_out_of_range, ref_frequency_value[11:0]}, 16'h0234);
    rd_chk(PLL_CONTROL_ADDR, 16'h0023);
    rd_chk(REF_FREQ_ADDR, 16'h5678);
    put(PLL_CONTROL_ADDR, 16'h0002);
    tick(1);
    check(ref_frequency_value, 16'h5678);
    rd_chk(MON_STATUS_ADDR, 16'h000F);
    $display("sleep test done");
    put(PLL_CONTROL_ADDR, 16'hFFDC);
    rd_chk(PLL_CONTROL_ADDR, 16'h0000);
    rd_chk(14'h0100, 16'h0000);
    $display("reserved and unmapped test done");
    report_and_stop();
  end
endmodule : dpll_monitor_control_tb_top
bind dpll_monitor_control dpll_monitor_control_properties chk_u (.clk, .rst, .host_req, .host_rdata, .det_freq,
  .active_ref, .ref_meas, .ref_frequency_value, .pll_run, .pll_sleep_mode, .strict_limit_select,
  .fixed_freq_source_enable, .ref_out_of_range);

//--- verilog/dpll_ctrl_pkg.sv
package dpll_ctrl_pkg;

  // Host port, reference and field widths
  localparam int          HOST_ADDR_W     = 14;
  localparam int          HOST_DATA_W     = 16;
  localparam int          NUM_REFS        = 4;
  localparam int          REF_SEL_W       = 2;
  localparam int          FREQ_W          = 16;
  localparam int          OFFSET_W        = 20;

  // Register addresses, word addressed on the 16-bit host port
  localparam logic [13:0] PLL_CONTROL_ADDR = 14'h0040;
  localparam logic [13:0] REF_FREQ_ADDR    = 14'h0041;
  localparam logic [13:0] MON_STATUS_ADDR  = 14'h0042;

  // Field positions in the control register
  localparam int          SLEEP_BIT        = 0;
  localparam int          FIXED_SRC_BIT    = 1;
  localparam int          STRICT_BIT       = 5;

  // Reset values
  localparam logic [15:0] PLL_CONTROL_RST  = 16'h0000;
  localparam logic [15:0] REF_FREQ_RST     = 16'h0000;
  localparam logic [15:0] READ_IDLE        = 16'h0000;

  // Monitor limits in thousandths of a ppm (64.713 ppm -> 64713)
  localparam logic [19:0] STRICT_INST_LIM  = 20'h0FCC9;  // 64.713 ppm
  localparam logic [19:0] STRICT_LONG_LIM  = 20'h14237;  // 82.487 ppm over 10 s
  localparam logic [19:0] RELAX_INST_LIM   = 20'h3A980;  // 240 ppm
  localparam logic [19:0] RELAX_LONG_LIM   = 20'h3D090;  // 250 ppm over 10 s

  // Host request carried as one bundle
  typedef struct packed {
    logic                    wr;
    logic                    rd;
    logic [HOST_ADDR_W-1:0]  addr;
    logic [HOST_DATA_W-1:0]  wdata;
  } host_req_t;

  // Offset measurements of one reference, two's complement milli-ppm
  typedef struct packed {
    logic signed [OFFSET_W-1:0] inst_offset;
    logic signed [OFFSET_W-1:0] long_offset;
  } ref_meas_t;

  typedef ref_meas_t [NUM_REFS-1:0]           ref_meas_arr_t;
  typedef logic [NUM_REFS-1:0][FREQ_W-1:0]    det_freq_arr_t;

endpackage : dpll_ctrl_pkg

//--- verilog/dpll_monitor_control.sv
// Summary of operation
// - Bit five high: monitors use 64.713 ppm and 82.487 ppm over ten seconds.
// - Bit five low: monitors use relaxed 240 ppm and 250 ppm over ten seconds.
// - Bit one low: loop frequency value comes from the selected reference's detector.
// - Bit one high: loop uses the software frequency register, detector ignored.
// - Bit zero low: the loop stays in normal operation.
// - Bit zero high: the loop enters power saving and stops operating.
// - Power saving resets no register; all written values are kept.
module dpll_monitor_control
  import dpll_ctrl_pkg::*;
(
  input  wire logic                  clk,                  // System clock, 100 MHz
  input  wire logic                  rst,                  // Async reset, active high
  input  wire host_req_t             host_req,             // Host port request, clk synchronous
  output logic [HOST_DATA_W-1:0]     host_rdata,           // Read data, valid cycle after rd
  input  wire det_freq_arr_t         det_freq,             // Detector frequency per reference
  input  wire logic [REF_SEL_W-1:0]  active_ref,           // Reference the loop tracks
  input  wire ref_meas_arr_t         ref_meas,             // Offset readings per reference
  output logic [FREQ_W-1:0]          ref_frequency_value,  // Frequency value fed to the loop
  output logic                       pll_run,              // High while the loop operates
  output logic                       pll_sleep_mode,       // Mirror of the sleep bit
  output logic                       strict_limit_select,  // Mirror of the limit bit
  output logic                       fixed_freq_source_enable, // Mirror of the source bit
  output logic [NUM_REFS-1:0]        ref_out_of_range      // Monitor verdict per reference
);

  // Control, frequency feed and readback state in one record; verdicts live in the range checkers
  typedef struct packed {
    logic                    strict;
    logic                    fixed_src;
    logic                    sleep;
    logic [FREQ_W-1:0]       ref_freq;
    logic [HOST_DATA_W-1:0]  rdata;
    logic [FREQ_W-1:0]       freq_out;
    logic                    run;
  } ctrl_state_t;

  ctrl_state_t st_ff;
  ctrl_state_t nxt_st;
  logic [NUM_REFS-1:0] oor;
  logic                wr_ctrl;
  logic                wr_freq;

  // Address match, used for both reads and writes
  function automatic logic hit(input logic [HOST_ADDR_W-1:0] a,
                               input logic [HOST_ADDR_W-1:0] target);
    hit = (a == target);
  endfunction : hit

  // Control readback; reserved bits always read zero
  function automatic logic [HOST_DATA_W-1:0] ctrl_word(input ctrl_state_t s);
    logic [HOST_DATA_W-1:0] w;
    w                = PLL_CONTROL_RST;
    w[STRICT_BIT]    = s.strict;
    w[FIXED_SRC_BIT] = s.fixed_src;
    w[SLEEP_BIT]     = s.sleep;
    ctrl_word        = w;
  endfunction : ctrl_word

  // Write strobes for the two writable registers
  assign wr_ctrl = host_req.wr && hit(host_req.addr, PLL_CONTROL_ADDR);
  assign wr_freq = host_req.wr && hit(host_req.addr, REF_FREQ_ADDR);

  // One range checker per reference
  for (genvar i = 0; i < NUM_REFS; i++) begin : g_mon
    ref_limit_check u_chk (
      .clk          (clk),
      .rst          (rst),
      .run          (st_ff.run),
      .strict       (st_ff.strict),
      .meas         (ref_meas[i]),
      .out_of_range (oor[i])
    );
  end

  // Next-state logic: register writes, readback and the loop frequency feed
  always_comb begin
    nxt_st = st_ff;

    // Only defined bits are stored; software keeps the others at zero
    if (wr_ctrl) begin
      nxt_st.strict    = host_req.wdata[STRICT_BIT];
      nxt_st.fixed_src = host_req.wdata[FIXED_SRC_BIT];
      nxt_st.sleep     = host_req.wdata[SLEEP_BIT];
    end

    // Frequency register stays writable while asleep
    if (wr_freq) begin
      nxt_st.ref_freq = host_req.wdata;
    end

    // Sleep only gates operation; no stored field is touched here
    nxt_st.run = !st_ff.sleep;

    // Loop frequency held while sleeping, so wake-up starts from the last value
    if (st_ff.run) begin
      if (st_ff.fixed_src) begin
        nxt_st.freq_out = st_ff.ref_freq;
      end else begin
        nxt_st.freq_out = det_freq[active_ref];
      end
    end

    // Read data registered; unmapped addresses answer zero
    nxt_st.rdata = READ_IDLE;
    if (host_req.rd) begin
      if (hit(host_req.addr, PLL_CONTROL_ADDR)) begin
        nxt_st.rdata = ctrl_word(st_ff);
      end else if (hit(host_req.addr, REF_FREQ_ADDR)) begin
        nxt_st.rdata = st_ff.ref_freq;
      end else if (hit(host_req.addr, MON_STATUS_ADDR)) begin
        nxt_st.rdata = {{(HOST_DATA_W-NUM_REFS){1'b0}}, oor};
      end else begin
        nxt_st.rdata = READ_IDLE;
      end
    end
  end

  // State register; reset clears every field, power saving clears none of the written ones
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs taken straight from flops
  assign host_rdata               = st_ff.rdata;
  assign ref_frequency_value      = st_ff.freq_out;
  assign pll_run                  = st_ff.run;
  assign pll_sleep_mode           = st_ff.sleep;
  assign strict_limit_select      = st_ff.strict;
  assign fixed_freq_source_enable = st_ff.fixed_src;
  assign ref_out_of_range         = oor;

endmodule : dpll_monitor_control

//--- verilog/ref_limit_check.sv
module ref_limit_check
  import dpll_ctrl_pkg::*;
(
  input  wire logic      clk,          // System clock
  input  wire logic      rst,          // Async reset, active high
  input  wire logic      run,          // Low while the loop sleeps
  input  wire logic      strict,       // Strict limit set chosen
  input  wire ref_meas_t meas,         // Offset readings of this reference
  output logic           out_of_range  // Reference exceeds the chosen limits
);

  typedef struct packed {
    logic flag;
  } chk_state_t;

  chk_state_t st_ff;
  chk_state_t nxt_st;
  logic [OFFSET_W-1:0] inst_lim;
  logic [OFFSET_W-1:0] long_lim;

  // Magnitude of a signed offset; both readings need it
  function automatic logic [OFFSET_W-1:0] mag(input logic signed [OFFSET_W-1:0] v);
    mag = v[OFFSET_W-1] ? OFFSET_W'(-v) : OFFSET_W'(v);
  endfunction : mag

  // Limit pair follows the select bit; sleeping freezes the verdict
  always_comb begin
    nxt_st   = st_ff;
    inst_lim = strict ? STRICT_INST_LIM : RELAX_INST_LIM;
    long_lim = strict ? STRICT_LONG_LIM : RELAX_LONG_LIM;
    if (run) begin
      nxt_st.flag = (mag(meas.inst_offset) > inst_lim) || (mag(meas.long_offset) > long_lim);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign out_of_range = st_ff.flag;

endmodule : ref_limit_check
